// ===== chanb_pinmux_params.svh
`ifndef CHANB_PINMUX_PARAMS_SVH
`define CHANB_PINMUX_PARAMS_SVH

// Register byte offsets
`define ADDR_BASE_CFG 8'h00
`define ADDR_BITMODE 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_PIN_IN 8'h0C

// Base configuration register fields
`define CFG_MODE_LSB 0
`define CFG_AOPTO_BIT 2
`define BASE_CFG_RST 2'b00

// Status register fields
`define ST_FUNC_LSB 0
`define ST_HOLD_BIT 3
`define ST_SIWU_BIT 4
`define ST_REJ_BIT 5
`define ST_AFREE_BIT 6

// Pin input snapshot fields
`define PIN_DATA_LSB 0
`define PIN_CTRL_LSB 8
`define PIN_SIWU_BIT 12

// Bit-mode command values
`define CMD_RESET 8'h00
`define CMD_ASYNC_BB 8'h01
`define CMD_SERIAL_ENG 8'h02
`define CMD_SYNC_BB 8'h04
`define CMD_MCU_BUS 8'h08
`define CMD_OPTO 8'h10

// Data pin roles
`define DP_TXD 0
`define DP_RXD 1
`define DP_CTS 3
`define DP_DSR 5
`define DP_DCD 6
`define DP_RI 7
`define DP_OPTO_IN 0

// Control pin roles
`define CP_FIFO_RD 2
`define CP_FIFO_WR 3
`define CP_BB_WR_FIFO 0
`define CP_BB_RD_FIFO 1
`define CP_BB_WR_UART 2
`define CP_BB_RD_UART 3

// Output enable patterns and idle pin input level
`define UART_DOE 8'h15
`define OPTO_DOE 8'h0E
`define FIFO_COE 4'h3
`define ALL_DOE 8'hFF
`define ALL_COE 4'hF
`define PIN_IDLE 13'h1FFF

`endif

// ===== chanb_pinmux_pkg.sv
package chanb_pinmux_pkg;

    typedef enum logic [1:0] {
        BASE_UART = 2'b00,
        BASE_FIFO = 2'b01,
        BASE_CPU_FIFO = 2'b10,
        BASE_OPTO = 2'b11
    } base_mode_t;

    typedef enum logic [2:0] {
        BM_BASE = 3'b000,
        BM_ASYNC_BB = 3'b001,
        BM_SYNC_BB = 3'b010,
        BM_SERIAL_ENG = 3'b011,
        BM_MCU = 3'b100,
        BM_OPTO_HOLD = 3'b101
    } bit_mode_t;

    typedef enum logic [2:0] {
        F_UART = 3'b000,
        F_FIFO = 3'b001,
        F_ASYNC_BB = 3'b010,
        F_SYNC_BB = 3'b011,
        F_MCU = 3'b100,
        F_OPTO = 3'b101,
        F_NONE = 3'b110
    } pin_func_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 13,
    parameter logic [W-1:0] RST = '1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= RST;
            s2_reg <= RST;
            s3_reg <= RST;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A bit moves only once the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q[i] <= s3_reg[i];
                end
            end
        end
    end
endmodule // pin_sync

// ===== bitmode_decode.sv
`timescale 1ns/1ps
`include "chanb_pinmux_params.svh"
module bitmode_decode (
    input wire logic [7:0] cmd,
    output chanb_pinmux_pkg::bit_mode_t mode,
    output logic valid
);
    import chanb_pinmux_pkg::*;

    always_comb begin
        mode = BM_BASE;
        valid = 1'b1;
        unique case (cmd)
            `CMD_RESET: mode = BM_BASE;
            `CMD_ASYNC_BB: mode = BM_ASYNC_BB;
            `CMD_SERIAL_ENG: mode = BM_SERIAL_ENG;
            `CMD_SYNC_BB: mode = BM_SYNC_BB;
            `CMD_MCU_BUS: mode = BM_MCU;
            `CMD_OPTO: mode = BM_OPTO_HOLD;
            default: valid = 1'b0;
        endcase
    end
endmodule // bitmode_decode

// ===== chanb_pinmux.sv
// Overview of operation
// - UART mode maps data pins to modem lines, control pins to enable/LEDs.
// - FIFO base puts parallel data on data pins, bit-bang strobes ctrl 0-1.
// - UART base puts bit-bang write strobe on ctrl 2, read on ctrl 3.
// - No bit-bang on this channel while opto-isolated serial is enabled.
// - Serial engine lives on the other channel; these pins get no function.
// - MCU bus mode drives upper address on data, CS/ALE/RD/WR on control.
// - Opto mode uses data pins 0-3 for serial in/clock/out/CTS; A freed unless A is opto too.
// - When both channels are opto, all opto signals use this channel.
// - Suspend/wake pin works except in serial engine and MCU bus modes.
// - Base modes come from config memory; bit modes from host commands.
// - Command 0 resets to base, 1 async bit-bang, 2 serial engine.
// - Command 4 sync bit-bang, 8 MCU bus, hex 10 opto serial.
// - Command hex 10 holds opto mode in reset, 0 releases it.
`timescale 1ns/1ps
`include "chanb_pinmux_params.svh"
module chanb_pinmux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg_valid,
    input wire chanb_pinmux_pkg::base_mode_t cfg_base_mode,
    input wire logic cfg_chana_opto,
    input wire logic [7:0] chanb_data_pin_in,
    output logic [7:0] chanb_data_pin_out,
    output logic [7:0] chanb_data_pin_oe,
    input wire logic [3:0] chanb_ctrl_pin_in,
    output logic [3:0] chanb_ctrl_pin_out,
    output logic [3:0] chanb_ctrl_pin_oe,
    input wire logic suspend_wake_pin_in,
    output logic suspend_wake_pin_out,
    output logic suspend_wake_pin_oe,
    input wire logic uart_txd,
    input wire logic uart_rts_n,
    input wire logic uart_dtr_n,
    input wire logic transmit_driver_enable,
    input wire logic uart_sleep_n,
    input wire logic receive_activity_led_n,
    input wire logic transmit_activity_led_n,
    output logic uart_rxd,
    output logic uart_cts_n,
    output logic uart_dsr_n,
    output logic uart_dcd_n,
    output logic uart_ri_n,
    input wire logic [7:0] fifo_dout,
    input wire logic fifo_doe,
    input wire logic receive_fifo_full_n,
    input wire logic transmit_empty_n,
    output logic [7:0] fifo_din,
    output logic fifo_rd_n,
    output logic fifo_wr,
    input wire logic [7:0] bb_dout,
    input wire logic [7:0] bb_doe,
    input wire logic bb_wr_n,
    input wire logic bb_rd_n,
    output logic [7:0] bb_din,
    input wire logic [7:0] mcu_addr_hi,
    input wire logic mcu_cs_n,
    input wire logic mcu_ale,
    input wire logic mcu_rd_n,
    input wire logic mcu_wr_n,
    input wire logic opto_serial_clock,
    input wire logic opto_serial_out,
    input wire logic opto_clear_to_send,
    output logic opto_serial_in,
    output logic opto_reset_hold,
    output logic chana_free,
    input wire logic suspend_ind,
    output logic wake_req,
    output chanb_pinmux_pkg::pin_func_t active_func
);
    import chanb_pinmux_pkg::*;

    base_mode_t base_reg;
    logic aopto_reg;
    bit_mode_t bm_reg;
    logic hold_reg;
    logic rej_reg;
    logic [7:0] cmd_reg;
    pin_func_t func;
    bit_mode_t dec_mode;
    logic dec_valid;
    logic [7:0] data_s;
    logic [3:0] ctrl_s;
    logic siwu_s;
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic cmd_ok;
    logic siwu_avail;
    logic bb_on;
    logic [31:0] rd_mux;
    logic [7:0] d_out_next;
    logic [7:0] d_oe_next;
    logic [3:0] c_out_next;
    logic [3:0] c_oe_next;

    // Pins are asynchronous to pclk; idle high matches the pull-ups
    pin_sync #(
        .W(13),
        .RST(`PIN_IDLE)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({suspend_wake_pin_in, chanb_ctrl_pin_in, chanb_data_pin_in}),
        .q({siwu_s, ctrl_s, data_s})
    );

    bitmode_decode u_dec (
        .cmd(pwdata[7:0]),
        .mode(dec_mode),
        .valid(dec_valid)
    );

    // Zero wait states; read data is fetched in the setup cycle
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        unique case (paddr)
            `ADDR_BASE_CFG, `ADDR_BITMODE, `ADDR_STATUS, `ADDR_PIN_IN:
                mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `ADDR_BASE_CFG: begin
                rd_mux[`CFG_MODE_LSB +: 2] = base_reg;
                rd_mux[`CFG_AOPTO_BIT] = aopto_reg;
            end
            `ADDR_BITMODE: rd_mux[7:0] = cmd_reg;
            `ADDR_STATUS: begin
                rd_mux[`ST_FUNC_LSB +: 3] = active_func;
                rd_mux[`ST_HOLD_BIT] = opto_reset_hold;
                rd_mux[`ST_SIWU_BIT] = siwu_avail;
                rd_mux[`ST_REJ_BIT] = rej_reg;
                rd_mux[`ST_AFREE_BIT] = chana_free;
            end
            `ADDR_PIN_IN: begin
                rd_mux[`PIN_DATA_LSB +: 8] = data_s;
                rd_mux[`PIN_CTRL_LSB +: 4] = ctrl_s;
                rd_mux[`PIN_SIWU_BIT] = siwu_s;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // Base mode is read-only to software; only config memory sets it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_reg <= BASE_UART;
            aopto_reg <= 1'b0;
        end else if (cfg_valid) begin
            base_reg <= cfg_base_mode;
            aopto_reg <= cfg_chana_opto;
        end
    end

    // Bit-bang requests are refused while the base mode is opto serial
    always_comb begin
        cmd_ok = dec_valid;
        if ((dec_mode == BM_ASYNC_BB || dec_mode == BM_SYNC_BB)
                && base_reg == BASE_OPTO) begin
            cmd_ok = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bm_reg <= BM_BASE;
            cmd_reg <= `CMD_RESET;
            rej_reg <= 1'b0;
        end else if (wr_en && paddr == `ADDR_BITMODE) begin
            rej_reg <= !cmd_ok;
            if (cmd_ok) begin
                cmd_reg <= pwdata[7:0];
                // Opto hold is tracked apart so the pin map stays put
                if (dec_mode != BM_OPTO_HOLD) begin
                    bm_reg <= dec_mode;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_reg <= 1'b0;
        end else if (wr_en && paddr == `ADDR_BITMODE && cmd_ok) begin
            if (dec_mode == BM_OPTO_HOLD) begin
                hold_reg <= 1'b1;
            end else if (dec_mode == BM_BASE) begin
                hold_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        func = F_UART;
        unique case (bm_reg)
            BM_BASE: begin
                unique case (base_reg)
                    BASE_UART: func = F_UART;
                    BASE_FIFO, BASE_CPU_FIFO: func = F_FIFO;
                    BASE_OPTO: func = F_OPTO;
                endcase
            end
            BM_ASYNC_BB: func = (base_reg == BASE_OPTO) ? F_OPTO
                : F_ASYNC_BB;
            BM_SYNC_BB: func = (base_reg == BASE_OPTO) ? F_OPTO
                : F_SYNC_BB;
            BM_SERIAL_ENG: func = F_NONE;
            BM_MCU: func = F_MCU;
            default: func = F_NONE;
        endcase
    end

    assign bb_on = (func == F_ASYNC_BB) || (func == F_SYNC_BB);
    assign siwu_avail = (func != F_NONE) && (func != F_MCU);

    always_comb begin
        d_out_next = 8'h00;
        d_oe_next = 8'h00;
        c_out_next = 4'h0;
        c_oe_next = 4'h0;
        unique case (func)
            F_UART: begin
                d_out_next = {1'b0, 1'b0, 1'b0, uart_dtr_n,
                              1'b0, uart_rts_n, 1'b0, uart_txd};
                d_oe_next = `UART_DOE;
                c_out_next = {transmit_activity_led_n,
                              receive_activity_led_n,
                              uart_sleep_n,
                              transmit_driver_enable};
                c_oe_next = `ALL_COE;
            end
            F_FIFO: begin
                d_out_next = fifo_dout;
                d_oe_next = {8{fifo_doe}};
                c_out_next = {2'b00, transmit_empty_n,
                              receive_fifo_full_n};
                c_oe_next = `FIFO_COE;
            end
            F_ASYNC_BB, F_SYNC_BB: begin
                d_out_next = bb_dout;
                d_oe_next = bb_doe;
                if (base_reg == BASE_UART) begin
                    c_out_next = {bb_rd_n, bb_wr_n, 2'b00};
                    c_oe_next = {2'b11, 2'b00};
                end else begin
                    c_out_next = {2'b00, bb_rd_n, bb_wr_n};
                    c_oe_next = `FIFO_COE;
                end
            end
            F_MCU: begin
                d_out_next = mcu_addr_hi;
                d_oe_next = `ALL_DOE;
                c_out_next = {mcu_wr_n, mcu_rd_n, mcu_ale,
                              mcu_cs_n};
                c_oe_next = `ALL_COE;
            end
            F_OPTO: begin
                // Opto IO always lands here, even with both channels opto
                d_out_next = {4'h0, opto_clear_to_send, opto_serial_out,
                              opto_serial_clock, 1'b0};
                d_oe_next = `OPTO_DOE;
            end
            default: begin
                d_out_next = 8'h00;
                d_oe_next = 8'h00;
            end
        endcase
    end

    // Registered pins so a mode change never glitches a pad
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chanb_data_pin_out <= 8'h00;
            chanb_data_pin_oe <= 8'h00;
            chanb_ctrl_pin_out <= 4'h0;
            chanb_ctrl_pin_oe <= 4'h0;
            suspend_wake_pin_oe <= 1'b0;
            wake_req <= 1'b0;
            active_func <= F_UART;
        end else begin
            chanb_data_pin_out <= d_out_next;
            chanb_data_pin_oe <= d_oe_next;
            chanb_ctrl_pin_out <= c_out_next;
            chanb_ctrl_pin_oe <= c_oe_next;
            suspend_wake_pin_oe <= siwu_avail && suspend_ind;
            wake_req <= siwu_avail && !siwu_s;
            active_func <= func;
        end
    end

    // Suspend indicate pulls the shared pin low only
    assign suspend_wake_pin_out = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uart_rxd <= 1'b1;
            uart_cts_n <= 1'b1;
            uart_dsr_n <= 1'b1;
            uart_dcd_n <= 1'b1;
            uart_ri_n <= 1'b1;
        end else begin
            uart_rxd <= (func == F_UART) ? data_s[`DP_RXD] : 1'b1;
            uart_cts_n <= (func == F_UART) ? data_s[`DP_CTS] : 1'b1;
            uart_dsr_n <= (func == F_UART) ? data_s[`DP_DSR] : 1'b1;
            uart_dcd_n <= (func == F_UART) ? data_s[`DP_DCD] : 1'b1;
            uart_ri_n <= (func == F_UART) ? data_s[`DP_RI] : 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_din <= 8'h00;
            fifo_rd_n <= 1'b1;
            fifo_wr <= 1'b0;
            bb_din <= 8'h00;
        end else begin
            fifo_din <= (func == F_FIFO) ? data_s : 8'h00;
            fifo_rd_n <= (func == F_FIFO) ? ctrl_s[`CP_FIFO_RD] : 1'b1;
            fifo_wr <= (func == F_FIFO) && ctrl_s[`CP_FIFO_WR];
            bb_din <= bb_on ? data_s : 8'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opto_serial_in <= 1'b1;
            opto_reset_hold <= 1'b0;
            chana_free <= 1'b0;
        end else begin
            opto_serial_in <= (func == F_OPTO) ?
                data_s[`DP_OPTO_IN] : 1'b1;
            opto_reset_hold <= hold_reg && base_reg == BASE_OPTO;
            chana_free <= base_reg == BASE_OPTO && !aopto_reg;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    uart_map_a: assert property (
        func == F_UART |=> chanb_data_pin_oe == `UART_DOE
            && chanb_ctrl_pin_oe == `ALL_COE
            && chanb_data_pin_out[`DP_TXD] == $past(uart_txd))
        else $error("uart pin map wrong");

    fifo_strobe_a: assert property (
        bb_on && base_reg != BASE_UART && base_reg != BASE_OPTO |=>
            chanb_ctrl_pin_out[`CP_BB_WR_FIFO] == $past(bb_wr_n)
            && chanb_ctrl_pin_out[`CP_BB_RD_FIFO] == $past(bb_rd_n))
        else $error("bit-bang strobes not on ctrl 0-1");

    uart_strobe_a: assert property (
        bb_on && base_reg == BASE_UART |=>
            chanb_ctrl_pin_out[`CP_BB_WR_UART] == $past(bb_wr_n)
            && chanb_ctrl_pin_out[`CP_BB_RD_UART] == $past(bb_rd_n))
        else $error("bit-bang strobes not on ctrl 2-3");

    opto_no_bb_a: assert property (
        wr_en && paddr == `ADDR_BITMODE && base_reg == BASE_OPTO && !cfg_valid
            && (pwdata[7:0] == `CMD_ASYNC_BB
            || pwdata[7:0] == `CMD_SYNC_BB)
            |=> bm_reg == $past(bm_reg) && rej_reg && !bb_on)
        else $error("bit-bang accepted in opto mode");

    engine_idle_a: assert property (
        bm_reg == BM_SERIAL_ENG |=>
            chanb_data_pin_oe == 8'h00 && chanb_ctrl_pin_oe == 4'h0)
        else $error("serial engine drives channel pins");

    mcu_addr_a: assert property (
        func == F_MCU |=> chanb_data_pin_out == $past(mcu_addr_hi)
            && chanb_data_pin_oe == `ALL_DOE)
        else $error("mcu address not on data pins");

    opto_map_a: assert property (
        func == F_OPTO |=> chanb_data_pin_oe == `OPTO_DOE
            && chanb_ctrl_pin_oe == 4'h0)
        else $error("opto pin map wrong");

    siwu_off_a: assert property (
        func == F_NONE || func == F_MCU |=>
            !suspend_wake_pin_oe && !wake_req)
        else $error("suspend pin active in excluded mode");

    cmd_decode_a: assert property (
        wr_en && paddr == `ADDR_BITMODE
            && pwdata[7:0] == `CMD_MCU_BUS
            |=> bm_reg == BM_MCU ##1 active_func == F_MCU)
        else $error("mcu command not decoded");

    opto_hold_a: assert property (
        wr_en && paddr == `ADDR_BITMODE && pwdata[7:0] == `CMD_OPTO
            && base_reg == BASE_OPTO && !cfg_valid
            |=> ##1 opto_reset_hold)
        else $error("opto hold not taken");

    bad_cmd_a: assert property (
        wr_en && paddr == `ADDR_BITMODE && !dec_valid |=>
            rej_reg && bm_reg == $past(bm_reg))
        else $error("invalid command changed mode");

    mcu_cov_c: cover property (active_func == F_MCU);
    opto_hold_c: cover property (opto_reset_hold ##1 !opto_reset_hold);
    uart_bb_c: cover property (bb_on && base_reg == BASE_UART);
    reject_c: cover property (rej_reg);
endmodule // chanb_pinmux

// ===== pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
    input wire logic [7:0] d_out,
    input wire logic [7:0] d_oe,
    input wire logic [3:0] c_out,
    input wire logic [3:0] c_oe,
    input wire logic s_oe,
    input wire logic [7:0] d_ext,
    input wire logic [3:0] c_ext,
    output logic [7:0] d_in,
    output logic [3:0] c_in,
    output logic s_in
);
    // The far side drives a pin only where the device has let go of it
    assign d_in = (d_out & d_oe) | (d_ext & ~d_oe);
    assign c_in = (c_out & c_oe) | (c_ext & ~c_oe);
    // Open-drain suspend line, pulled up when nobody sinks it
    assign s_in = ~s_oe;
endmodule // pin_partner

// ===== channel_b_pin_mode_mux_test.sv
`timescale 1ns/1ps
`include "chanb_pinmux_params.svh"
module channel_b_pin_mode_mux_test;
    import chanb_pinmux_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cfg_valid, cfg_chana_opto, suspend_ind, wake_req;
    logic suspend_wake_pin_in, suspend_wake_pin_out, suspend_wake_pin_oe;
    base_mode_t cfg_base_mode;
    logic [7:0] chanb_data_pin_in, chanb_data_pin_out, chanb_data_pin_oe;
    logic [3:0] chanb_ctrl_pin_in, chanb_ctrl_pin_out, chanb_ctrl_pin_oe;
    logic [7:0] d_ext;
    logic [3:0] c_ext;
    logic uart_txd, uart_rts_n, uart_dtr_n, transmit_driver_enable;
    logic uart_sleep_n, receive_activity_led_n, transmit_activity_led_n;
    logic uart_rxd, uart_cts_n, uart_dsr_n, uart_dcd_n, uart_ri_n;
    logic [7:0] fifo_dout, fifo_din, bb_dout, bb_doe, bb_din, mcu_addr_hi;
    logic fifo_doe, receive_fifo_full_n, transmit_empty_n, fifo_rd_n, fifo_wr;
    logic bb_wr_n, bb_rd_n, mcu_cs_n, mcu_ale, mcu_rd_n, mcu_wr_n;
    logic opto_serial_clock, opto_serial_out, opto_clear_to_send;
    logic opto_serial_in, opto_reset_hold, chana_free;
    pin_func_t active_func;
    int err_count, checks_done, cyc;
    logic [7:0] cv [5] = '{`CMD_ASYNC_BB, `CMD_SERIAL_ENG, `CMD_SYNC_BB,
        `CMD_MCU_BUS, `CMD_RESET};
    pin_func_t fx [5] = '{F_ASYNC_BB, F_NONE, F_SYNC_BB, F_MCU, F_UART};
    logic av [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

    chanb_pinmux i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cfg_valid, .cfg_base_mode,
        .cfg_chana_opto, .chanb_data_pin_in, .chanb_data_pin_out,
        .chanb_data_pin_oe, .chanb_ctrl_pin_in, .chanb_ctrl_pin_out,
        .chanb_ctrl_pin_oe, .suspend_wake_pin_in, .suspend_wake_pin_out,
        .suspend_wake_pin_oe, .uart_txd, .uart_rts_n, .uart_dtr_n,
        .transmit_driver_enable, .uart_sleep_n, .receive_activity_led_n,
        .transmit_activity_led_n, .uart_rxd, .uart_cts_n, .uart_dsr_n,
        .uart_dcd_n, .uart_ri_n, .fifo_dout, .fifo_doe,
        .receive_fifo_full_n, .transmit_empty_n, .fifo_din, .fifo_rd_n,
        .fifo_wr, .bb_dout, .bb_doe, .bb_wr_n, .bb_rd_n, .bb_din,
        .mcu_addr_hi, .mcu_cs_n, .mcu_ale, .mcu_rd_n, .mcu_wr_n,
        .opto_serial_clock, .opto_serial_out, .opto_clear_to_send,
        .opto_serial_in, .opto_reset_hold, .chana_free, .suspend_ind,
        .wake_req, .active_func);

    pin_partner i_far (.d_out(chanb_data_pin_out), .d_oe(chanb_data_pin_oe),
        .c_out(chanb_ctrl_pin_out), .c_oe(chanb_ctrl_pin_oe),
        .s_oe(suspend_wake_pin_oe), .d_ext(d_ext), .c_ext(c_ext),
        .d_in(chanb_data_pin_in), .c_in(chanb_ctrl_pin_in),
        .s_in(suspend_wake_pin_in));

    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A hung handshake must not stall the run forever
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            $display("unexpected %0t run timed out", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Entered just after a rising edge; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        chk(pslverr, err, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cmd(input logic [7:0] v);
        apb(1'b1, `ADDR_BITMODE, {24'h000000, v}, 1'b0);
        wt(3);
    endtask

    task automatic base(input base_mode_t b, input logic ao);
        cfg_base_mode <= b;
        cfg_chana_opto <= ao;
        cfg_valid <= 1'b1;
        wt(1);
        cfg_valid <= 1'b0;
        wt(3);
    endtask

    initial begin
        {psel, penable, pwrite, cfg_valid, cfg_chana_opto} = '0;
        {paddr, pwdata, cyc, err_count, checks_done} = '0;
        cfg_base_mode = BASE_UART;
        {uart_txd, uart_rts_n, uart_dtr_n, transmit_driver_enable} = 4'h6;
        {uart_sleep_n, receive_activity_led_n, transmit_activity_led_n} = 3'h2;
        {fifo_dout, fifo_doe, receive_fifo_full_n, transmit_empty_n} = '1;
        {bb_dout, bb_doe, bb_wr_n, bb_rd_n} = {8'hA5, 8'h3C, 2'b01};
        {mcu_addr_hi, mcu_cs_n, mcu_ale, mcu_rd_n, mcu_wr_n} = 12'h5A6;
        {opto_serial_clock, opto_serial_out, opto_clear_to_send} = 3'h5;
        suspend_ind = 1'b1;
        d_ext = 8'hD4;
        c_ext = 4'hA;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wt(7);
        chk(active_func, F_UART, "uart func");
        chk(chanb_data_pin_oe, `UART_DOE, "uart data oe");
        chk(chanb_data_pin_out & `UART_DOE, 8'h14, "uart data");
        chk(chanb_ctrl_pin_oe, `ALL_COE, "uart ctrl oe");
        chk(chanb_ctrl_pin_out, 4'h4, "uart ctrl");
        chk({uart_rxd, uart_cts_n}, 2'b00, "uart inputs");
        chk({uart_dsr_n, uart_dcd_n, uart_ri_n}, 3'b011, "uart status");
        for (int i = 0; i < 5; i++) begin
            cmd(cv[i]);
            chk(active_func, fx[i], "command func");
            chk(suspend_wake_pin_oe, av[i], "suspend pin");
            apb(1'b0, `ADDR_STATUS, 32'h0, 1'b0);
            chk(rd[4], av[i], "suspend status");
            apb(1'b0, `ADDR_BITMODE, 32'h0, 1'b0);
            chk(rd[7:0], cv[i], "bitmode readback");
            if (fx[i] == F_ASYNC_BB || fx[i] == F_SYNC_BB) begin
                chk(chanb_ctrl_pin_out[3:2], 2'b10, "bb strobes");
                chk(chanb_data_pin_oe, bb_doe, "bb data oe");
                chk(chanb_data_pin_out & bb_doe, 8'h24, "bb data");
            end
            if (fx[i] == F_MCU) begin
                chk(chanb_data_pin_out, 8'h5A, "mcu addr");
                chk(chanb_data_pin_oe, `ALL_DOE, "mcu addr oe");
                chk(chanb_ctrl_pin_out, 4'h6, "mcu ctrl");
            end
            if (fx[i] == F_NONE) begin
                chk({chanb_data_pin_oe, chanb_ctrl_pin_oe}, 12'h0, "eng");
            end
        end
        cmd(8'h03);
        chk(active_func, F_UART, "bad command func");
        apb(1'b0, `ADDR_STATUS, 32'h0, 1'b0);
        chk(rd[5], 1'b1, "bad command flag");
        apb(1'b0, `ADDR_BITMODE, 32'h0, 1'b0);
        chk(rd[7:0], 8'h00, "bad command kept");
        apb(1'b0, 8'h10, 32'h0, 1'b1);
        chk(rd, 32'h0, "unmapped read");
        apb(1'b1, `ADDR_BASE_CFG, 32'hFF, 1'b0);
        apb(1'b0, `ADDR_BASE_CFG, 32'h0, 1'b0);
        chk(rd[2:0], 3'h0, "base cfg read only");
        fifo_dout <= 8'h3C;
        for (int j = 0; j < 2; j++) begin
            base(j == 0 ? BASE_FIFO : BASE_CPU_FIFO, 1'b0);
            chk(active_func, F_FIFO, "fifo func");
            chk(chanb_data_pin_out, 8'h3C, "fifo data");
            chk(chanb_data_pin_oe, `ALL_DOE, "fifo data oe");
            cmd(`CMD_ASYNC_BB);
            chk(chanb_ctrl_pin_out[1:0], 2'b10, "fifo bb strobes");
            cmd(`CMD_RESET);
            chk({fifo_rd_n, fifo_wr}, 2'b01, "fifo strobes");
        end
        base(BASE_OPTO, 1'b0);
        chk(active_func, F_OPTO, "opto func");
        chk(chanb_data_pin_oe, `OPTO_DOE, "opto oe");
        chk(chanb_data_pin_out[3:1], 3'b101, "opto outputs");
        chk(opto_serial_in, 1'b0, "opto input");
        chk(chana_free, 1'b1, "channel a free");
        chk(suspend_wake_pin_oe, 1'b1, "opto suspend");
        for (int k = 0; k < 2; k++) begin
            cmd(k == 0 ? `CMD_ASYNC_BB : `CMD_SYNC_BB);
            chk(active_func, F_OPTO, "no bb in opto");
            apb(1'b0, `ADDR_STATUS, 32'h0, 1'b0);
            chk(rd[5], 1'b1, "bb refused");
        end
        cmd(`CMD_OPTO);
        chk(opto_reset_hold, 1'b1, "opto hold");
        cmd(`CMD_RESET);
        chk(opto_reset_hold, 1'b0, "opto release");
        base(BASE_OPTO, 1'b1);
        chk(chana_free, 1'b0, "both opto");
        chk(chanb_data_pin_oe, `OPTO_DOE, "both opto oe");
        end_of_test();
    end
endmodule // channel_b_pin_mode_mux_test
